// File: hw/ep_buffer_decode.sv
/*
 * Decodes an endpoint_select value into the targeted buffer.
 * Assumes a registered select value on its input; purely combinational.
 */
`timescale 1ns/1ps
`default_nettype none
module ep_buffer_decode
	import ep_select_pkg::*;
(
	input wire logic [7:0] sel_i,
	output logic [BUF_IDX_W-1:0] buf_idx_o,
	output logic is_setup_o,
	output logic is_control_o,
	output logic is_in_o
);
	always_comb
	begin
		buf_idx_o = {sel_i[SEL_NUM_MSB:SEL_NUM_LSB], sel_i[SEL_DIR_BIT]};
		is_setup_o = sel_i[SEL_SETUP_BIT];
		is_control_o = (sel_i[SEL_NUM_MSB:SEL_NUM_LSB] == 3'h0) && !sel_i[SEL_SETUP_BIT];
		is_in_o = sel_i[SEL_DIR_BIT] && !sel_i[SEL_SETUP_BIT];
	end
endmodule
`default_nettype wire

// File: hw/ep_link_if.sv
/*
 * Parallel register link between the microcontroller end and the device end.
 * Assumes both ends run on the same clock; req is a one-cycle request.
 */
`timescale 1ns/1ps
`default_nettype none
interface ep_link_if;
	logic req;
	logic we;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic rvalid;

	modport device (input req, input we, input addr, input wdata, output rdata, output rvalid);
	modport host (output req, output we, output addr, output wdata, input rdata, input rvalid);
endinterface
`default_nettype wire

// File: hw/ep_select_device.sv
/*
 * Device end: endpoint_select and endpoint_function_control registers,
 * per-buffer stall state, clear/validate command pulses and control
 * transfer data/status stage gating toward the USB engine.
 * Assumes the link and the engine run on clk_i; engine inputs are pulses.
 */
// What this block does
// - select register steers every indexed register access
// - host writes 02h to reach endpoint 1 OUT
// - host keeps select and DMA endpoint apart
// - host waits 400 ns after select write
// - select layout: setup bit5, number 3:1, dir 0
// - host writes reserved bits with reset values
// - setup bit targets setup buffer; else cleared
// - direction 0 is OUT fifo, 1 IN fifo
// - buffer decode from setup, number, direction
// - function actions hit indexed endpoint if enabled
// - host writes select before control function access
// - clear bit 4 discards indexed receive buffer
// - receive buffer cleared automatically after full read
// - host clears double buffer with two commands
// - validate bit 3 marks IN fifo ready
// - auto validate when byte count reaches max
// - control OUT data stage NAKed until enabled
// - host enables data stage before IN data
// - host may ack status straight after setup
// - status bit 1 NAK/ack, cleared after status
// - stall bit 0 stalls, not on isochronous
`timescale 1ns/1ps
`default_nettype none
module ep_select_device
	import ep_select_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	ep_link_if.device link,
	input wire logic usb_bus_reset_i,
	input wire logic [BUF_COUNT-1:0] ep_enabled_i,
	input wire logic [BUF_COUNT-1:0] ep_isochronous_i,
	input wire logic rx_read_done_i,
	input wire logic tx_count_full_i,
	input wire logic setup_received_i,
	input wire logic status_done_i,
	output logic [BUF_IDX_W-1:0] sel_buffer_o,
	output logic sel_setup_o,
	output logic rx_clear_o,
	output logic [BUF_IDX_W-1:0] rx_clear_buffer_o,
	output logic tx_validate_o,
	output logic [BUF_IDX_W-1:0] tx_validate_buffer_o,
	output logic [BUF_COUNT-1:0] stall_o,
	output logic data_stage_enable_o,
	output logic data_stage_nak_o,
	output logic status_ack_o,
	output logic status_nak_o
);
	logic [7:0] sel_ff;
	logic [7:0] nxt_sel;
	logic [BUF_COUNT-1:0] stall_ff;
	logic [BUF_COUNT-1:0] nxt_stall;
	logic dse_ff;
	logic nxt_dse;
	logic status_ff;
	logic nxt_status;
	logic rx_clear_ff;
	logic nxt_rx_clear;
	logic [BUF_IDX_W-1:0] rx_buf_ff;
	logic [BUF_IDX_W-1:0] nxt_rx_buf;
	logic tx_val_ff;
	logic nxt_tx_val;
	logic [BUF_IDX_W-1:0] tx_buf_ff;
	logic [BUF_IDX_W-1:0] nxt_tx_buf;
	logic [7:0] rdata_ff;
	logic [7:0] nxt_rdata;
	logic rvalid_ff;
	logic nxt_rvalid;

	logic [BUF_IDX_W-1:0] buf_idx;
	logic is_setup;
	logic is_control;
	logic is_in;
	logic sel_wr;
	logic func_wr;
	logic act;

	ep_buffer_decode u_decode (
		.sel_i(sel_ff),
		.buf_idx_o(buf_idx),
		.is_setup_o(is_setup),
		.is_control_o(is_control),
		.is_in_o(is_in)
	);

	always_comb
	begin
		sel_wr = link.req && link.we && (link.addr == OFF_SEL);
		func_wr = link.req && link.we && (link.addr == OFF_FUNC);
		act = func_wr && ep_enabled_i[buf_idx];

		nxt_sel = sel_ff;
		if (sel_wr)
		begin
			nxt_sel = link.wdata;
		end

		nxt_stall = stall_ff;
		if (act && !ep_isochronous_i[buf_idx])
		begin
			nxt_stall[buf_idx] = link.wdata[FUNC_STALL_BIT];
		end

		// engine events apply first so a write in the same cycle wins
		nxt_dse = dse_ff;
		if (setup_received_i)
		begin
			nxt_dse = 1'b0;
		end
		if (act && is_control)
		begin
			nxt_dse = link.wdata[FUNC_DSE_BIT];
		end

		nxt_status = status_ff;
		if (status_done_i || setup_received_i)
		begin
			nxt_status = 1'b0;
		end
		if (act && (is_control || is_setup))
		begin
			nxt_status = link.wdata[FUNC_STATUS_BIT];
		end

		// forced clear and read-out completion share one pulse
		nxt_rx_clear = (act && link.wdata[FUNC_CLEAR_BIT] && !is_in) || rx_read_done_i;
		nxt_rx_buf = buf_idx;
		// validate only makes sense on an IN fifo
		nxt_tx_val = (act && link.wdata[FUNC_VALIDATE_BIT] && is_in) || tx_count_full_i;
		nxt_tx_buf = buf_idx;

		nxt_rvalid = link.req && !link.we;
		case (link.addr)
			OFF_SEL: nxt_rdata = sel_ff;
			OFF_FUNC: nxt_rdata = {5'h00, dse_ff, status_ff, stall_ff[buf_idx]};
			default: nxt_rdata = 8'h00;
		endcase

		if (usb_bus_reset_i)
		begin
			nxt_sel = SEL_RESET;
			nxt_stall = '0;
			nxt_dse = FUNC_RESET[FUNC_DSE_BIT];
			nxt_status = FUNC_RESET[FUNC_STATUS_BIT];
			nxt_rx_clear = 1'b0;
			nxt_tx_val = 1'b0;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			sel_ff <= SEL_RESET;
			stall_ff <= '0;
			dse_ff <= 1'b0;
			status_ff <= 1'b0;
			rx_clear_ff <= 1'b0;
			rx_buf_ff <= '0;
			tx_val_ff <= 1'b0;
			tx_buf_ff <= '0;
			rdata_ff <= 8'h00;
			rvalid_ff <= 1'b0;
		end
		else
		begin
			sel_ff <= nxt_sel;
			stall_ff <= nxt_stall;
			dse_ff <= nxt_dse;
			status_ff <= nxt_status;
			rx_clear_ff <= nxt_rx_clear;
			rx_buf_ff <= nxt_rx_buf;
			tx_val_ff <= nxt_tx_val;
			tx_buf_ff <= nxt_tx_buf;
			rdata_ff <= nxt_rdata;
			rvalid_ff <= nxt_rvalid;
		end
	end

	assign link.rdata = rdata_ff;
	assign link.rvalid = rvalid_ff;
	assign sel_buffer_o = buf_idx;
	assign sel_setup_o = is_setup;
	assign rx_clear_o = rx_clear_ff;
	assign rx_clear_buffer_o = rx_buf_ff;
	assign tx_validate_o = tx_val_ff;
	assign tx_validate_buffer_o = tx_buf_ff;
	assign stall_o = stall_ff;
	assign data_stage_enable_o = dse_ff;
	assign data_stage_nak_o = !dse_ff;
	assign status_ack_o = status_ff;
	assign status_nak_o = !status_ff;
endmodule
`default_nettype wire

// File: hw/ep_select_host.sv
/*
 * Microcontroller end: takes orders over a classic Wishbone slave and
 * drives the link with select writes, control function writes and reads.
 * Assumes one clock shared with the device; Wishbone data is 32 bits.
 */
`timescale 1ns/1ps
`default_nettype none
module ep_select_host
	import ep_select_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	ep_link_if.host link
);
	host_state_e state_ff;
	host_state_e nxt_state;
	logic [7:0] selv_ff;
	logic [7:0] nxt_selv;
	logic [7:0] funcv_ff;
	logic [7:0] nxt_funcv;
	logic [3:0] dma_ff;
	logic [3:0] nxt_dma;
	logic [3:0] ops_ff;
	logic [3:0] nxt_ops;
	logic [1:0] pass_ff;
	logic [1:0] nxt_pass;
	logic [SETTLE_W-1:0] cnt_ff;
	logic [SETTLE_W-1:0] nxt_cnt;
	logic selected_ff;
	logic nxt_selected;
	logic err_conf_ff;
	logic nxt_err_conf;
	logic err_order_ff;
	logic nxt_err_order;
	logic [7:0] readback_ff;
	logic [7:0] nxt_readback;
	logic ack_ff;
	logic nxt_ack;
	logic [31:0] dat_ff;
	logic [31:0] nxt_dat;
	logic req_ff;
	logic nxt_req;
	logic we_ff;
	logic nxt_we;
	logic [7:0] addr_ff;
	logic [7:0] nxt_addr;
	logic [7:0] wdata_ff;
	logic [7:0] nxt_wdata;
	logic wb_wr;
	logic [7:0] fval;

	always_comb
	begin
		nxt_state = state_ff;
		nxt_selv = selv_ff;
		nxt_funcv = funcv_ff;
		nxt_dma = dma_ff;
		nxt_ops = ops_ff;
		nxt_pass = pass_ff;
		nxt_cnt = cnt_ff;
		nxt_selected = selected_ff;
		nxt_err_conf = err_conf_ff;
		nxt_err_order = err_order_ff;
		nxt_readback = readback_ff;
		nxt_req = 1'b0;
		nxt_we = we_ff;
		nxt_addr = addr_ff;
		nxt_wdata = wdata_ff;
		fval = funcv_ff;

		// registered ack: request answered one cycle after it appears
		nxt_ack = wb_cyc_i && wb_stb_i && !ack_ff;
		wb_wr = wb_cyc_i && wb_stb_i && wb_we_i && ack_ff && wb_sel_i[0];
		nxt_dat = dat_ff;
		if (nxt_ack)
		begin
			case (wb_adr_i)
				HOFF_CTRL: nxt_dat = {28'h0000000, ops_ff};
				HOFF_SEL: nxt_dat = {24'h000000, selv_ff};
				HOFF_FUNC: nxt_dat = {24'h000000, funcv_ff};
				HOFF_DMA: nxt_dat = {28'h0000000, dma_ff};
				HOFF_STATUS: nxt_dat = {16'h0000, readback_ff, 5'h00, err_order_ff,
					err_conf_ff, (state_ff != H_IDLE)};
				default: nxt_dat = 32'h00000000;
			endcase
		end
		if (wb_wr && state_ff == H_IDLE)
		begin
			case (wb_adr_i)
				HOFF_SEL: nxt_selv = wb_dat_i[7:0];
				HOFF_FUNC: nxt_funcv = wb_dat_i[7:0];
				HOFF_DMA: nxt_dma = wb_dat_i[3:0];
				HOFF_CTRL:
				begin
					nxt_ops = wb_dat_i[3:0];
					nxt_err_conf = 1'b0;
					nxt_err_order = 1'b0;
					nxt_pass = 2'h0;
					if (wb_dat_i[CTRL_DO_SEL])
					begin
						// refuse a select that names the DMA endpoint
						if (dma_ff[DMA_EN_BIT] &&
							selv_ff[SEL_NUM_MSB:SEL_NUM_LSB] == dma_ff[2:0])
						begin
							nxt_err_conf = 1'b1;
						end
						else
						begin
							nxt_state = H_SEL;
						end
					end
					else if (wb_dat_i[CTRL_DO_FUNC] || wb_dat_i[CTRL_DO_READ])
					begin
						if (!selected_ff)
						begin
							nxt_err_order = 1'b1;
						end
						else if (wb_dat_i[CTRL_DO_FUNC])
						begin
							nxt_state = H_FUNC;
						end
						else
						begin
							nxt_state = H_READ;
						end
					end
				end
				default: nxt_state = state_ff;
			endcase
		end

		case (state_ff)
			H_IDLE: nxt_req = 1'b0;
			H_SEL:
			begin
				nxt_req = 1'b1;
				nxt_we = 1'b1;
				nxt_addr = OFF_SEL;
				// e.g. 8'h02 reaches endpoint 1 OUT
				nxt_wdata = (selv_ff & ~SEL_RSV_MASK) | (SEL_RESET & SEL_RSV_MASK);
				nxt_selected = 1'b1;
				nxt_cnt = SETTLE_W'(SETTLE_CYC);
				nxt_state = H_SETTLE;
			end
			H_SETTLE:
			begin
				// no link access at all until the select has settled
				nxt_cnt = cnt_ff - SETTLE_W'(1);
				if (cnt_ff == SETTLE_W'(1))
				begin
					if (ops_ff[CTRL_DO_FUNC])
					begin
						nxt_state = H_FUNC;
					end
					else if (ops_ff[CTRL_DO_READ])
					begin
						nxt_state = H_READ;
					end
					else
					begin
						nxt_state = H_IDLE;
					end
				end
			end
			H_FUNC:
			begin
				fval = (funcv_ff & ~FUNC_RSV_MASK) | (FUNC_RESET & FUNC_RSV_MASK);
				if (ops_ff[CTRL_DBL_CLEAR])
				begin
					// set, release, set, release empties both halves
					fval[FUNC_CLEAR_BIT] = !pass_ff[0];
				end
				nxt_req = 1'b1;
				nxt_we = 1'b1;
				nxt_addr = OFF_FUNC;
				nxt_wdata = fval;
				nxt_pass = pass_ff + 2'h1;
				if (!ops_ff[CTRL_DBL_CLEAR] || pass_ff == 2'h3)
				begin
					nxt_state = ops_ff[CTRL_DO_READ] ? H_READ : H_IDLE;
				end
			end
			H_READ:
			begin
				nxt_req = 1'b1;
				nxt_we = 1'b0;
				nxt_addr = OFF_FUNC;
				nxt_state = H_WAITR;
			end
			H_WAITR:
			begin
				if (link.rvalid)
				begin
					nxt_readback = link.rdata;
					nxt_state = H_IDLE;
				end
			end
			default: nxt_state = H_IDLE;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state_ff <= H_IDLE;
			selv_ff <= SEL_RESET;
			funcv_ff <= FUNC_RESET;
			dma_ff <= 4'h0;
			ops_ff <= 4'h0;
			pass_ff <= 2'h0;
			cnt_ff <= '0;
			selected_ff <= 1'b0;
			err_conf_ff <= 1'b0;
			err_order_ff <= 1'b0;
			readback_ff <= 8'h00;
			ack_ff <= 1'b0;
			dat_ff <= 32'h00000000;
			req_ff <= 1'b0;
			we_ff <= 1'b0;
			addr_ff <= 8'h00;
			wdata_ff <= 8'h00;
		end
		else
		begin
			state_ff <= nxt_state;
			selv_ff <= nxt_selv;
			funcv_ff <= nxt_funcv;
			dma_ff <= nxt_dma;
			ops_ff <= nxt_ops;
			pass_ff <= nxt_pass;
			cnt_ff <= nxt_cnt;
			selected_ff <= nxt_selected;
			err_conf_ff <= nxt_err_conf;
			err_order_ff <= nxt_err_order;
			readback_ff <= nxt_readback;
			ack_ff <= nxt_ack;
			dat_ff <= nxt_dat;
			req_ff <= nxt_req;
			we_ff <= nxt_we;
			addr_ff <= nxt_addr;
			wdata_ff <= nxt_wdata;
		end
	end

	assign wb_ack_o = ack_ff;
	assign wb_dat_o = dat_ff;
	assign link.req = req_ff;
	assign link.we = we_ff;
	assign link.addr = addr_ff;
	assign link.wdata = wdata_ff;
endmodule
`default_nettype wire

// File: hw/ep_select_pkg.sv
/*
 * Shared constants for the endpoint buffer select block: link register
 * offsets, field positions, reset values, host-side register map and timing.
 * Assumes a single 250 MHz clock shared by both ends of the link.
 */
package ep_select_pkg;

	localparam int EP_NUM_W = 3;
	localparam int BUF_IDX_W = EP_NUM_W + 1;
	localparam int BUF_COUNT = 1 << BUF_IDX_W;

	// device registers on the link
	localparam logic [7:0] OFF_FUNC = 8'h28;
	localparam logic [7:0] OFF_SEL = 8'h2C;

	// endpoint_select fields
	localparam int SEL_SETUP_BIT = 5;
	localparam int SEL_NUM_LSB = 1;
	localparam int SEL_NUM_MSB = 3;
	localparam int SEL_DIR_BIT = 0;
	localparam logic [7:0] SEL_RESET = 8'h20;
	localparam logic [7:0] SEL_RSV_MASK = 8'hD0;

	// endpoint_function_control fields
	localparam int FUNC_CLEAR_BIT = 4;
	localparam int FUNC_VALIDATE_BIT = 3;
	localparam int FUNC_DSE_BIT = 2;
	localparam int FUNC_STATUS_BIT = 1;
	localparam int FUNC_STALL_BIT = 0;
	localparam logic [7:0] FUNC_RESET = 8'h00;
	localparam logic [7:0] FUNC_RSV_MASK = 8'hE0;

	// settle time after an endpoint_select write
	localparam int CLK_PERIOD_NS = 4;
	localparam int SETTLE_NS = 400;
	localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SETTLE_W = 8;

	// host-side Wishbone registers
	localparam logic [7:0] HOFF_CTRL = 8'h00;
	localparam logic [7:0] HOFF_SEL = 8'h04;
	localparam logic [7:0] HOFF_FUNC = 8'h08;
	localparam logic [7:0] HOFF_DMA = 8'h0C;
	localparam logic [7:0] HOFF_STATUS = 8'h10;
	localparam int CTRL_DO_SEL = 0;
	localparam int CTRL_DO_FUNC = 1;
	localparam int CTRL_DO_READ = 2;
	localparam int CTRL_DBL_CLEAR = 3;
	localparam int DMA_EN_BIT = 3;
	localparam int STAT_BUSY = 0;
	localparam int STAT_ERR_CONFLICT = 1;
	localparam int STAT_ERR_ORDER = 2;
	localparam int STAT_READBACK_LSB = 8;

	typedef enum logic [2:0] {
		H_IDLE = 3'b000,
		H_SEL = 3'b001,
		H_SETTLE = 3'b011,
		H_FUNC = 3'b010,
		H_READ = 3'b110,
		H_WAITR = 3'b111
	} host_state_e;

endpackage

// File: sim/endpoint_buffer_select_control_test.sv
/*
 * Bench: drives the host end over Wishbone and the device end's engine inputs.
 * Assumes both ends share clk_i and the link interface between them.
 */
`timescale 1ns/1ps
`default_nettype none
module endpoint_buffer_select_control_test
	import ep_select_pkg::*;
;
	logic clk_i, rst_i, cs, wwe, sel_setup_o, rx_clear_o, tx_validate_o, wb_ack_o;
	logic data_stage_enable_o, data_stage_nak_o, status_ack_o, status_nak_o;
	logic [7:0] adr;
	logic [3:0] bsel;
	logic [31:0] wdat, rd, wb_dat_o;
	logic [4:0] eng;
	logic [BUF_COUNT-1:0] en, iso, stall_o;
	logic [BUF_IDX_W-1:0] sel_buffer_o, clr_b, val_b, clr_buf, val_buf;
	int bad_count, n_compared, n_clr, n_val;
	ep_link_if link();
	ep_select_host u_ep_select_host (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cs),
		.wb_stb_i(cs), .wb_we_i(wwe), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(bsel),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .link(link));
	ep_select_device u_ep_select_device (.clk_i(clk_i), .rst_i(rst_i), .link(link),
		.usb_bus_reset_i(eng[4]), .ep_enabled_i(en), .ep_isochronous_i(iso),
		.rx_read_done_i(eng[0]), .tx_count_full_i(eng[1]), .setup_received_i(eng[2]),
		.status_done_i(eng[3]), .sel_buffer_o(sel_buffer_o), .sel_setup_o(sel_setup_o),
		.rx_clear_o(rx_clear_o), .rx_clear_buffer_o(clr_b), .tx_validate_o(tx_validate_o),
		.tx_validate_buffer_o(val_b), .stall_o(stall_o),
		.data_stage_enable_o(data_stage_enable_o), .data_stage_nak_o(data_stage_nak_o),
		.status_ack_o(status_ack_o), .status_nak_o(status_nak_o));
	ep_link_chk u_ep_link_chk (.clk_i(clk_i), .rst_i(rst_i), .req(link.req), .we(link.we),
		.addr(link.addr), .wdata(link.wdata), .rdata(link.rdata), .rvalid(link.rvalid));
	initial
	begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	// pulses last one cycle, so tally them here rather than poll
	always @(posedge clk_i)
	begin
		if (rx_clear_o === 1'b1)
		begin
			n_clr++;
			clr_buf = clr_b;
		end
		if (tx_validate_o === 1'b1)
		begin
			n_val++;
			val_buf = val_b;
		end
	end
	task automatic close_out();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic tmo();
		bad_count++;
		$display("ERROR t=%0t wait ran out", $time);
		close_out();
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e)
		begin
			bad_count++;
			$display("ERROR t=%0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clk_i);
		cs <= 1'b1;
		wwe <= w;
		adr <= a;
		wdat <= d;
		k = 0;
		do
		begin
			@(posedge clk_i);
			k++;
		end
		while (wb_ack_o !== 1'b1 && k < 50);
		rd = wb_dat_o;
		cs <= 1'b0;
		if (k >= 50)
			tmo();
	endtask
	// leaves the last status word in rd
	task automatic idle();
		int k;
		k = 0;
		do
		begin
			wb(1'b0, HOFF_STATUS, 32'h0);
			k++;
		end
		while (rd[STAT_BUSY] !== 1'b0 && k < 100);
		if (k >= 100)
			tmo();
	endtask
	task automatic cmd(input logic [7:0] s, input logic [7:0] f, input logic [3:0] c);
		wb(1'b1, HOFF_SEL, {24'h0, s});
		wb(1'b1, HOFF_FUNC, {24'h0, f});
		wb(1'b1, HOFF_CTRL, {28'h0, c});
		idle();
	endtask
	task automatic pulse(input logic [4:0] m);
		@(posedge clk_i);
		eng <= m;
		@(posedge clk_i);
		eng <= 5'h00;
		repeat (3) @(posedge clk_i);
	endtask
	initial
	begin
		rst_i = 1'b1;
		cs = 1'b0;
		wwe = 1'b0;
		adr = 8'h00;
		wdat = 32'h0;
		bsel = 4'hF;
		eng = 5'h00;
		en = 16'hFFFF;
		iso = 16'h0040;
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b0, HOFF_SEL, 32'h0);
		chk(rd, 32'h20);
		chk({sel_setup_o, sel_buffer_o, data_stage_nak_o, status_nak_o, stall_o}, {5'h10, 2'b11, 16'h0});
		cmd(8'h00, 8'h10, 4'h2);
		chk({rd[STAT_ERR_ORDER], n_clr[7:0]}, {1'b1, 8'h00});
		for (int i = 0; i < 16; i++)
		begin
			cmd(8'(i) | SEL_RSV_MASK, 8'h00, 4'h1);
			chk({sel_setup_o, sel_buffer_o}, 5'(i));
		end
		cmd(8'h20, 8'h00, 4'h1);
		chk({sel_setup_o, sel_buffer_o}, 5'h10);
		cmd(8'h02, 8'h10, 4'h3);
		chk({n_clr[7:0], clr_buf}, {8'h01, 4'h2});
		cmd(8'h03, 8'h18, 4'h3);
		chk({n_clr[7:0], n_val[7:0], val_buf}, {8'h01, 8'h01, 4'h3});
		en <= 16'hFFFB;
		cmd(8'h02, 8'h10, 4'h3);
		chk(n_clr, 1);
		en <= 16'hFFFF;
		cmd(8'h02, 8'h00, 4'hB);
		chk(n_clr, 3);
		pulse(5'h01);
		chk({n_clr[7:0], clr_buf}, {8'h04, 4'h2});
		cmd(8'h03, 8'h00, 4'h1);
		pulse(5'h02);
		chk({n_val[7:0], val_buf}, {8'h02, 4'h3});
		cmd(8'h04, 8'h01, 4'h7);
		chk({stall_o, rd[15:8]}, {16'h0010, 8'h01});
		cmd(8'h06, 8'h01, 4'h3);
		chk(stall_o, 16'h0010);
		cmd(8'h00, 8'h04, 4'h3);
		chk({data_stage_enable_o, data_stage_nak_o}, 2'b10);
		pulse(5'h04);
		chk({data_stage_enable_o, data_stage_nak_o}, 2'b01);
		// control IN: data stage enabled first, then the short packet validated
		cmd(8'h01, 8'h04, 4'h3);
		cmd(8'h01, 8'h0C, 4'h3);
		chk({data_stage_enable_o, n_val[7:0], val_buf}, {1'b1, 8'h03, 4'h1});
		cmd(8'h00, 8'h02, 4'h3);
		chk({status_ack_o, status_nak_o}, 2'b10);
		pulse(5'h08);
		chk({status_ack_o, status_nak_o}, 2'b01);
		cmd(8'h02, 8'h04, 4'h3);
		chk(data_stage_enable_o, 1'b0);
		wb(1'b1, HOFF_DMA, 32'h0A);
		cmd(8'h05, 8'h00, 4'h1);
		chk({rd[STAT_ERR_CONFLICT], sel_buffer_o}, {1'b1, 4'h2});
		wb(1'b1, HOFF_DMA, 32'h0);
		pulse(5'h10);
		chk({sel_setup_o, sel_buffer_o, stall_o}, {5'h10, 16'h0});
		bsel <= 4'h0;
		wb(1'b1, HOFF_SEL, 32'h33);
		bsel <= 4'hF;
		wb(1'b0, HOFF_SEL, 32'h0);
		chk(rd, 32'h05);
		wb(1'b0, 8'h40, 32'h0);
		chk(rd, 32'h0);
		close_out();
	end
endmodule
`default_nettype wire

// File: sim/ep_link_chk.sv
/*
 * Link checker: concurrent checks on the request/answer link between ends.
 * Assumes one clock and a synchronous active-high reset on both ends.
 */
`timescale 1ns/1ps
`default_nettype none
module ep_link_chk
	import ep_select_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic req,
	input wire logic we,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic [7:0] rdata,
	input wire logic rvalid
);
	logic [7:0] gap_ff;
	logic [7:0] nxt_gap;
	logic seen_ff;
	logic nxt_seen;
	wire logic sel_wr = req && we && addr == OFF_SEL;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// cycles since the last select write; saturates so idle time never wraps
	always_comb
	begin
		nxt_gap = (gap_ff == 8'hFF) ? gap_ff : gap_ff + 8'h01;
		nxt_seen = seen_ff | sel_wr;
		if (sel_wr)
			nxt_gap = 8'h01;
	end
	always_ff @(posedge clk_i)
	begin
		gap_ff <= rst_i ? 8'hFF : nxt_gap;
		seen_ff <= rst_i ? 1'b0 : nxt_seen;
	end
	a_read_answer: assert property (req && !we |=> rvalid)
		else $error("read request got no answer next cycle");
	a_answer_cause: assert property (rvalid |-> $past(req) && !$past(we))
		else $error("read answer without a read request");
	a_mapped_addr: assert property (req |-> addr == OFF_SEL || addr == OFF_FUNC)
		else $error("request to an unexpected offset");
	a_settle_gap: assert property (req |-> gap_ff >= SETTLE_CYC)
		else $error("request too soon after a select write");
	a_sel_reserved: assert property (sel_wr |-> (wdata & SEL_RSV_MASK) == 8'h00)
		else $error("select write with reserved bits set");
	a_func_reserved: assert property (req && we && addr == OFF_FUNC |-> wdata[7:5] == 3'h0)
		else $error("function write with reserved bits set");
	a_sel_first: assert property (req && addr == OFF_FUNC |-> seen_ff)
		else $error("function access before any select write");
	a_func_readback: assert property (rvalid && $past(addr) == OFF_FUNC |-> rdata[7:3] == 5'h00)
		else $error("function readback shows command bits");
endmodule
`default_nettype wire
